// File: core/sfpw_cfg.svh
`ifndef SFPW_CFG_SVH
`define SFPW_CFG_SVH

// Opcodes
`define SFPW_OP_WRAP      8'h77
`define SFPW_OP_PGM       8'h02
`define SFPW_OP_QPGM      8'h32
`define SFPW_OP_SECT      8'h20
`define SFPW_OP_BLK32     8'h52
`define SFPW_OP_BLK64     8'hd8
`define SFPW_OP_STAT_LO   8'h05
`define SFPW_OP_STAT_HI   8'h35

// Frame layout
`define SFPW_HDR_BYTES    2'h3
`define SFPW_WRAP_DIS_POS 4
`define SFPW_WRAP_LEN_LO  5
`define SFPW_WRAP_LEN_HI  6
`define SFPW_WRAP_RST     3'h1
`define SFPW_WRAP_MASK_RST 6'h07
`define SFPW_PAGE_LAST    8'hff

// Region sizes in bytes
`define SFPW_SECTOR_BYTES 24'h001000
`define SFPW_BLK32_BYTES  24'h008000
`define SFPW_BLK64_BYTES  24'h010000
`define SFPW_MEM_BYTES    24'h080000

// Self-timed cycle lengths
`define SFPW_CLK_MHZ      10
`define SFPW_T_PGM_US     40
`define SFPW_T_ERA_US     500
`define SFPW_PGM_CYC      (`SFPW_T_PGM_US * `SFPW_CLK_MHZ)
`define SFPW_ERA_CYC      (`SFPW_T_ERA_US * `SFPW_CLK_MHZ)

`endif

// File: core/sfpw_pkg.sv
package sfpw_pkg;

  typedef enum logic [3:0] {
    D_OPC  = 4'h1,
    D_HDR  = 4'h2,
    D_DATA = 4'h4,
    D_SKIP = 4'h8
  } sfpw_dec_t;

  typedef enum logic [3:0] {
    E_IDLE  = 4'h1,
    E_PGM   = 4'h2,
    E_ERASE = 4'h4,
    E_WAIT  = 4'h8
  } sfpw_exec_t;

  typedef enum logic [1:0] {
    K_SECTOR = 2'h0,
    K_BLK32  = 2'h1,
    K_BLK64  = 2'h2
  } sfpw_erase_t;

endpackage

// File: core/sfpw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfpw_sync #(
  parameter int           W   = 6,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // Two flops per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_r;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          meta_r <= RST[i];
          q[i]   <= RST[i];
        end
        else
        begin
          meta_r <= d[i];
          q[i]   <= meta_r;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: core/sfpw_page_buf.sv
`timescale 1ns/1ps
`default_nettype none
module sfpw_page_buf #(
  parameter int AW = 8
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          clr,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata,
  output logic               rvalid
);
  logic [7:0]       mem [0:(1<<AW)-1];
  logic [(1<<AW)-1:0] valid_r;

  // Array needs no reset; valid flags say which bytes were loaded
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // A later byte to the same column replaces the earlier one
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      valid_r <= '0;
    else if (clr)
      valid_r <= '0;
    else if (we)
      valid_r[waddr] <= 1'b1;
  end

  // Registered read port
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end
    else
    begin
      rdata  <= mem[raddr];
      rvalid <= valid_r[raddr];
    end
  end
endmodule
`default_nettype wire

// File: core/sfpw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "sfpw_cfg.svh"
module sfpw_top #(
  parameter logic [23:0] MEM_BYTES = `SFPW_MEM_BYTES,
  parameter int          PGM_CYC   = `SFPW_PGM_CYC,
  parameter int          ERA_CYC   = `SFPW_ERA_CYC
) (
  input  wire logic                 CLK_SYS,
  input  wire logic                 SYS_RST,
  input  wire logic                 CS_N,
  input  wire logic                 SCLK,
  input  wire logic [3:0]           IO_IN,
  input  wire logic                 WRITE_ENABLE_LATCH,
  input  wire logic                 QUAD_ENABLE_BIT,
  input  wire logic [4:0]           BLOCK_PROTECT_BITS,
  output logic                      WRITE_IN_PROGRESS_FLAG,
  output logic                      WRITE_ENABLE_CLEAR,
  output logic                      CMD_REJECTED,
  output logic [2:0]                WRAP_SETTING_BITS,
  output logic                      WRAP_ENABLE,
  output logic [5:0]                WRAP_MASK,
  output logic                      MEM_PGM_STB,
  output logic                      MEM_ERASE_STB,
  output sfpw_pkg::sfpw_erase_t     MEM_ERASE_KIND,
  output logic [23:0]               MEM_ADDR,
  output logic [7:0]                MEM_WDATA
);
  import sfpw_pkg::*;

  logic        cs_s;
  logic        sclk_s;
  logic [3:0]  io_s;
  logic        cs_d_r;
  logic        sclk_d_r;
  logic        cs_rise;
  logic        sclk_rise;
  sfpw_dec_t   dec_r;
  sfpw_exec_t  exec_r;
  logic [7:0]  opcode_r;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [2:0]  bit_cnt_r;
  logic [3:0]  bit_sum;
  logic        byte_done;
  logic        quad_r;
  logic [1:0]  hdr_cnt_r;
  logic        hdr_done_r;
  logic [1:0]  data_cnt_r;
  logic [23:0] addr_r;
  logic [7:0]  col_r;
  logic        is_pgm;
  logic        is_erase;
  logic        buf_we;
  logic        buf_clr;
  logic [7:0]  buf_rdata;
  logic        buf_rvalid;
  logic [7:0]  rd_idx_r;
  logic [7:0]  rd_idx_d_r;
  logic        pgm_d_r;
  logic [23:0] prot_size;
  logic [23:0] era_size;
  logic [23:0] era_start;
  logic [23:0] era_last;
  logic [23:0] pg_start;
  logic        pgm_hit;
  logic        era_hit;
  logic        at_boundary;
  logic        start_pgm;
  logic        start_era;
  logic        start_wrap;
  logic        busy_reject;
  logic [23:0] exec_addr_r;
  sfpw_erase_t exec_kind_r;
  logic [23:0] timer_r;

  // Pins come from the host's domain; two flops before any use
  sfpw_sync #(.W(6), .RST(6'h20)) u_sync (
    .clk (CLK_SYS),
    .rst (SYS_RST),
    .d   ({CS_N, SCLK, IO_IN}),
    .q   ({cs_s, sclk_s, io_s})
  );

  // Edge finders on the synchronised select and serial clock
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cs_d_r   <= 1'b1;
      sclk_d_r <= 1'b0;
    end
    else
    begin
      cs_d_r   <= cs_s;
      sclk_d_r <= sclk_s;
    end
  end

  assign cs_rise   = cs_s & ~cs_d_r;
  assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;

  // MSB first; quad frames take a nibble per edge, IO3 highest
  assign shift_nxt = quad_r ? {shift_r[3:0], io_s} : {shift_r[6:0], io_s[0]};
  assign bit_sum   = {1'b0, bit_cnt_r} + (quad_r ? 4'h4 : 4'h1);
  assign byte_done = sclk_rise & bit_sum[3];
  assign is_pgm    = (opcode_r == `SFPW_OP_PGM) | (opcode_r == `SFPW_OP_QPGM);
  assign is_erase  = (opcode_r == `SFPW_OP_SECT) | (opcode_r == `SFPW_OP_BLK32) |
                     (opcode_r == `SFPW_OP_BLK64);

  // Anything but a status read is turned away while a cycle runs
  assign busy_reject = byte_done & (dec_r == D_OPC) & WRITE_IN_PROGRESS_FLAG &
                       (shift_nxt != `SFPW_OP_STAT_LO) & (shift_nxt != `SFPW_OP_STAT_HI);

  // Command decoder; reset to opcode phase whenever select is high
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      dec_r      <= D_OPC;
      opcode_r   <= 8'h00;
      shift_r    <= 8'h00;
      bit_cnt_r  <= 3'h0;
      quad_r     <= 1'b0;
      hdr_cnt_r  <= 2'h0;
      hdr_done_r <= 1'b0;
      data_cnt_r <= 2'h0;
      addr_r     <= 24'h000000;
      col_r      <= 8'h00;
    end
    else if (cs_s)
    begin
      dec_r      <= D_OPC;
      bit_cnt_r  <= 3'h0;
      quad_r     <= 1'b0;
      hdr_cnt_r  <= 2'h0;
      hdr_done_r <= 1'b0;
      data_cnt_r <= 2'h0;
    end
    else if (sclk_rise)
    begin
      shift_r   <= shift_nxt;
      bit_cnt_r <= bit_sum[2:0];
      if (byte_done)
      begin
        case (dec_r)
          D_OPC:
          begin
            opcode_r <= shift_nxt;
            // Quad lines only with quad enable; else a plain single-line program
            quad_r   <= (shift_nxt == `SFPW_OP_QPGM) & QUAD_ENABLE_BIT;
            if (busy_reject)
              dec_r <= D_SKIP;
            else if ((shift_nxt == `SFPW_OP_WRAP) | (shift_nxt == `SFPW_OP_PGM) |
                     (shift_nxt == `SFPW_OP_QPGM) | (shift_nxt == `SFPW_OP_SECT) |
                     (shift_nxt == `SFPW_OP_BLK32) | (shift_nxt == `SFPW_OP_BLK64))
              dec_r <= D_HDR;
            else
              dec_r <= D_SKIP;
          end
          D_HDR:
          begin
            // Address bytes, or the 24 dummy bits of a wrap setup
            addr_r    <= {addr_r[15:0], shift_nxt};
            hdr_cnt_r <= hdr_cnt_r + 2'h1;
            if (hdr_cnt_r == (`SFPW_HDR_BYTES - 2'h1))
            begin
              hdr_done_r <= 1'b1;
              col_r      <= shift_nxt;
              dec_r      <= D_DATA;
            end
          end
          D_DATA:
          begin
            if (data_cnt_r != 2'h3)
              data_cnt_r <= data_cnt_r + 2'h1;
            col_r <= col_r + 8'h01;
          end
          D_SKIP:
            dec_r <= D_SKIP;
          default:
            dec_r <= D_SKIP;
        endcase
      end
    end
  end

  // Page buffer load: column wraps inside the page, later bytes overwrite
  assign buf_clr = byte_done & (dec_r == D_OPC) & ~busy_reject &
                   ((shift_nxt == `SFPW_OP_PGM) | (shift_nxt == `SFPW_OP_QPGM));
  assign buf_we  = byte_done & (dec_r == D_DATA) & is_pgm;

  sfpw_page_buf #(.AW(8)) u_buf (
    .clk    (CLK_SYS),
    .rst    (SYS_RST),
    .clr    (buf_clr),
    .we     (buf_we),
    .waddr  (col_r),
    .wdata  (shift_nxt),
    .raddr  (rd_idx_r),
    .rdata  (buf_rdata),
    .rvalid (buf_rvalid)
  );

  // Protected region: protect bits 2..0 give 4KB << n (nothing for 0), bit 3 picks bottom, bit 4 guards all
  always_comb
  begin
    prot_size = (BLOCK_PROTECT_BITS[2:0] == 3'h0) ? 24'h000000 :
                (`SFPW_SECTOR_BYTES << BLOCK_PROTECT_BITS[2:0]);
    case (opcode_r)
      `SFPW_OP_SECT:  era_size = `SFPW_SECTOR_BYTES;
      `SFPW_OP_BLK32: era_size = `SFPW_BLK32_BYTES;
      default:       era_size = `SFPW_BLK64_BYTES;
    endcase
    era_start = addr_r & ~(era_size - 24'h000001);
    era_last  = era_start + era_size - 24'h000001;
    pg_start  = {addr_r[23:8], 8'h00};
  end

  // Region hit test against the low or high end of the array
  function automatic logic prot_hit(input logic [23:0] lo, input logic [23:0] hi,
                                    input logic [23:0] psz, input logic [4:0] bp);
    logic hit;
    hit = 1'b0;
    if (bp[4])
      hit = 1'b1;
    else if (psz != 24'h000000)
      hit = bp[3] ? (lo < psz) : (hi >= (MEM_BYTES - psz));
    return hit;
  endfunction

  assign pgm_hit = prot_hit(pg_start, pg_start | 24'h0000ff, prot_size, BLOCK_PROTECT_BITS);
  assign era_hit = prot_hit(era_start, era_last, prot_size, BLOCK_PROTECT_BITS);

  // Release must land exactly on a byte edge of a complete frame
  assign at_boundary = (bit_cnt_r == 3'h0) & (dec_r == D_DATA);
  assign start_pgm  = cs_rise & at_boundary & is_pgm & (data_cnt_r != 2'h0) &
                      WRITE_ENABLE_LATCH & ~pgm_hit & ~WRITE_IN_PROGRESS_FLAG;
  assign start_era  = cs_rise & at_boundary & is_erase & hdr_done_r & (data_cnt_r == 2'h0) &
                      WRITE_ENABLE_LATCH & ~era_hit & ~WRITE_IN_PROGRESS_FLAG;
  assign start_wrap = cs_rise & at_boundary & (opcode_r == `SFPW_OP_WRAP) &
                      (data_cnt_r == 2'h1) & ~WRITE_IN_PROGRESS_FLAG;

  // Wrap setting kept for the quad read engine
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      WRAP_SETTING_BITS <= `SFPW_WRAP_RST;
      WRAP_ENABLE       <= 1'b0;
      WRAP_MASK         <= `SFPW_WRAP_MASK_RST;
    end
    else if (start_wrap)
    begin
      WRAP_SETTING_BITS <= shift_r[`SFPW_WRAP_LEN_HI:`SFPW_WRAP_DIS_POS];
      WRAP_ENABLE       <= ~shift_r[`SFPW_WRAP_DIS_POS];
      WRAP_MASK         <= 6'((8'h08 << shift_r[`SFPW_WRAP_LEN_HI:`SFPW_WRAP_LEN_LO]) - 8'h01);
    end
  end

  // Reject pulse for any command but a status read that arrives during a busy cycle
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
      CMD_REJECTED <= 1'b0;
    else
      CMD_REJECTED <= busy_reject;
  end

  // Self-timed cycle: stream buffer out for a program, then wait out the cell time
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      exec_r                 <= E_IDLE;
      WRITE_IN_PROGRESS_FLAG <= 1'b0;
      WRITE_ENABLE_CLEAR     <= 1'b0;
      exec_addr_r            <= 24'h000000;
      exec_kind_r            <= K_SECTOR;
      timer_r                <= 24'h000000;
      rd_idx_r               <= 8'h00;
    end
    else
    begin
      WRITE_ENABLE_CLEAR <= 1'b0;
      case (exec_r)
        E_IDLE:
        begin
          rd_idx_r <= 8'h00;
          if (start_pgm)
          begin
            WRITE_IN_PROGRESS_FLAG <= 1'b1;
            exec_addr_r            <= pg_start;
            exec_r                 <= E_PGM;
          end
          else if (start_era)
          begin
            WRITE_IN_PROGRESS_FLAG <= 1'b1;
            exec_addr_r            <= era_start;
            exec_kind_r            <= (opcode_r == `SFPW_OP_SECT) ? K_SECTOR :
                                      (opcode_r == `SFPW_OP_BLK32) ? K_BLK32 : K_BLK64;
            exec_r                 <= E_ERASE;
          end
        end
        E_PGM:
        begin
          rd_idx_r <= rd_idx_r + 8'h01;
          if (rd_idx_r == `SFPW_PAGE_LAST)
          begin
            timer_r <= 24'(PGM_CYC);
            exec_r  <= E_WAIT;
          end
        end
        E_ERASE:
        begin
          timer_r <= 24'(ERA_CYC);
          exec_r  <= E_WAIT;
        end
        E_WAIT:
        begin
          timer_r <= timer_r - 24'h000001;
          if (timer_r == 24'h000002)
            WRITE_ENABLE_CLEAR <= 1'b1;
          if (timer_r <= 24'h000001)
          begin
            WRITE_IN_PROGRESS_FLAG <= 1'b0;
            exec_r                 <= E_IDLE;
          end
        end
        default:
          exec_r <= E_IDLE;
      endcase
    end
  end

  // Array strobes, registered after the one-cycle buffer read: two cycles behind the buffer index
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pgm_d_r       <= 1'b0;
      rd_idx_d_r    <= 8'h00;
      MEM_PGM_STB   <= 1'b0;
      MEM_ERASE_STB <= 1'b0;
      MEM_ERASE_KIND <= K_SECTOR;
      MEM_ADDR      <= 24'h000000;
      MEM_WDATA     <= 8'h00;
    end
    else
    begin
      pgm_d_r       <= (exec_r == E_PGM);
      rd_idx_d_r    <= rd_idx_r;
      MEM_PGM_STB   <= pgm_d_r & buf_rvalid;
      MEM_ERASE_STB <= (exec_r == E_ERASE);
      MEM_ERASE_KIND <= exec_kind_r;
      MEM_WDATA     <= buf_rdata;
      MEM_ADDR      <= pgm_d_r ? {exec_addr_r[23:8], rd_idx_d_r} : exec_addr_r;
    end
  end

  property p_busy_start;
    @(posedge CLK_SYS) disable iff (SYS_RST) (start_pgm | start_era) |=> WRITE_IN_PROGRESS_FLAG;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy flag not raised at start");

  property p_busy_hold;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (exec_r == E_WAIT) && (timer_r > 24'h000001) |=> WRITE_IN_PROGRESS_FLAG;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy flag dropped early");

  property p_latch_clr;
    @(posedge CLK_SYS) disable iff (SYS_RST) $fell(WRITE_IN_PROGRESS_FLAG) |-> $past(WRITE_ENABLE_CLEAR);
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared before cycle end");

  property p_no_busy_start;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      WRITE_IN_PROGRESS_FLAG |-> !(start_pgm || start_era || start_wrap);
  endproperty
  a_no_busy_start: assert property (p_no_busy_start) else $error("command started while busy");

  property p_prot_pgm;
    @(posedge CLK_SYS) disable iff (SYS_RST) start_pgm |-> !pgm_hit && !BLOCK_PROTECT_BITS[4] && WRITE_ENABLE_LATCH;
  endproperty
  a_prot_pgm: assert property (p_prot_pgm) else $error("program to protected page");

  property p_prot_era;
    @(posedge CLK_SYS) disable iff (SYS_RST) start_era |-> !era_hit && !BLOCK_PROTECT_BITS[4] && (data_cnt_r == 2'h0);
  endproperty
  a_prot_era: assert property (p_prot_era) else $error("erase of protected region");

  property p_boundary;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (cs_rise && (bit_cnt_r != 3'h0) && !WRITE_IN_PROGRESS_FLAG) |=> (exec_r == E_IDLE) && !MEM_ERASE_STB;
  endproperty
  a_boundary: assert property (p_boundary) else $error("frame cut mid byte executed");

  property p_wrap_load;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      start_wrap |=> (WRAP_ENABLE == !$past(shift_r[4])) && (WRAP_SETTING_BITS == $past(shift_r[6:4]));
  endproperty
  a_wrap_load: assert property (p_wrap_load) else $error("wrap setting not stored");

  property p_page_wrap;
    @(posedge CLK_SYS) disable iff (SYS_RST)
      (buf_we && (col_r == `SFPW_PAGE_LAST)) |=> (col_r == 8'h00) || cs_s;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("column left the page");

  property p_reject;
    @(posedge CLK_SYS) disable iff (SYS_RST) busy_reject |=> CMD_REJECTED ##1 !CMD_REJECTED;
  endproperty
  a_reject: assert property (p_reject) else $error("busy reject not pulsed");

  property p_erase_strobe;
    @(posedge CLK_SYS) disable iff (SYS_RST) start_era |=> ##1 MEM_ERASE_STB;
  endproperty
  a_erase_strobe: assert property (p_erase_strobe) else $error("erase strobe missing");
endmodule
`default_nettype wire

// File: verification/sfpw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host side of the serial link; the serial clock idles low between frames
module sfpw_host_model (
  output logic       cs_n,
  output logic       sclk,
  output logic [3:0] io
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    io   = 4'h5;
  end

  // One serial clock; data is set up a half period before the rise
  task automatic tick(input logic [3:0] v);
    io = v;
    #400 sclk = 1'b1;
    #400 sclk = 1'b0;
  endtask

  // Byte out MSB first; idle quad lines toggle so nothing stale is read
  task automatic put(input logic [7:0] bv, input bit q);
    if (q)
    begin
      tick(bv[7:4]);
      tick(bv[3:0]);
    end
    else
      for (int k = 7; k >= 0; k--)
        tick({~io[3:1], bv[k]});
  endtask

  // Opcode, address bytes, patterned data, then optional stray bits
  task automatic send(input logic [7:0] op, input logic [23:0] a, input int na, input int nd,
                      input logic [7:0] bv, input bit q, input int stray);
    cs_n = 1'b0;
    #400;
    put(op, 1'b0);
    for (int i = 0; i < na; i++)
      put(a[23-8*i -: 8], q);
    for (int i = 0; i < nd; i++)
      put(bv + 8'(i) * 8'h3b, q);
    for (int i = 0; i < stray; i++)
      tick(~io);
    #400 cs_n = 1'b1;
    io = ~io;
    #400;
  endtask
endmodule
`default_nettype wire

// File: verification/serial_flash_program_erase_wrap_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, a, e); end end
module serial_flash_program_erase_wrap_bench;
  import sfpw_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst, cs_n, sclk, we_latch, quad_en, busy, we_clr, rej, wrap_en, pgm_stb, ers_stb;
  logic        busy_q = 1'b0;
  logic [3:0]  io;
  logic [4:0]  bp;
  logic [2:0]  wrap_bits;
  logic [5:0]  wrap_mask;
  logic [23:0] mem_addr, pg_a, ers_a;
  logic [7:0]  mem_wdata;
  logic [7:0]  mem [256];
  sfpw_erase_t ers_kind, ers_k;
  int          num_errors, total_checks, pgm_cnt, ers_cnt, rej_cnt, rises;
  int          seed = 32'h7af2;
  int          nd [5] = '{3, 2, 258, 4, 5};
  logic [7:0]  eop [3] = '{8'h20, 8'h52, 8'hd8};
  sfpw_erase_t ekind [3] = '{K_SECTOR, K_BLK32, K_BLK64};
  logic [23:0] esz [3] = '{24'h001000, 24'h008000, 24'h010000};

  // Short self-timed counts keep the run brief
  sfpw_top #(.PGM_CYC(20), .ERA_CYC(30)) dut_u (
    .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CS_N(cs_n), .SCLK(sclk), .IO_IN(io),
    .WRITE_ENABLE_LATCH(we_latch), .QUAD_ENABLE_BIT(quad_en), .BLOCK_PROTECT_BITS(bp),
    .WRITE_IN_PROGRESS_FLAG(busy), .WRITE_ENABLE_CLEAR(we_clr), .CMD_REJECTED(rej),
    .WRAP_SETTING_BITS(wrap_bits), .WRAP_ENABLE(wrap_en), .WRAP_MASK(wrap_mask),
    .MEM_PGM_STB(pgm_stb), .MEM_ERASE_STB(ers_stb), .MEM_ERASE_KIND(ers_kind),
    .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata)
  );
  sfpw_host_model host_u (.cs_n(cs_n), .sclk(sclk), .io(io));

  always #50 clk_sys = ~clk_sys;

  // Record array requests; the outside latch drops on the core's request
  always @(posedge clk_sys)
  begin
    busy_q <= busy;
    if (busy && !busy_q)
      rises++;
    if (pgm_stb)
    begin
      pgm_cnt++;
      mem[mem_addr[7:0]] = mem_wdata;
      pg_a = mem_addr;
    end
    if (ers_stb)
    begin
      ers_cnt++;
      ers_a = mem_addr;
      ers_k = ers_kind;
    end
    if (rej)
      rej_cnt++;
    if (we_clr)
    begin
      `CHK(busy, 1'b1)
      we_latch <= 1'b0;
    end
  end

  function automatic logic [7:0] dat(input logic [7:0] bv, input int i);
    return bv + 8'(i) * 8'h3b;
  endfunction

  task automatic launch(input logic [7:0] op, input logic [23:0] a, input int na, input int n,
                        input logic [7:0] bv, input bit q, input int stray);
    pgm_cnt = 0;
    ers_cnt = 0;
    rej_cnt = 0;
    rises = 0;
    host_u.send(op, a, na, n, bv, q, stray);
  endtask

  // Bounded wait for the busy cycle to end; a refused frame never starts one
  task automatic settle(input int go);
    int t;
    t = 0;
    while (t < 400 && !(rises > 0 && busy === 1'b0))
    begin
      @(posedge clk_sys);
      t++;
    end
    #1;
    `CHK(rises, go)
  endtask

  // Only the columns the frame touched, last writer wins
  task automatic pchk(input logic [23:0] a, input int n, input logic [7:0] bv);
    int lo;
    lo = (n > 256) ? n - 256 : 0;
    `CHK(pgm_cnt, n - lo)
    `CHK(pg_a[23:8], a[23:8])
    `CHK(we_latch, 1'b0)
    for (int i = lo; i < n; i++)
      `CHK(mem[8'(a[7:0] + 8'(i))], dat(bv, i))
  endtask

  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    logic [23:0] a;
    logic [7:0]  bv;
    sys_rst = 1'b1;
    we_latch = 1'b0;
    quad_en = 1'b0;
    bp = 5'h00;
    repeat (10) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    // All four wrap lengths, then back to linear
    for (int w = 0; w < 5; w++)
    begin
      launch(8'h77, 24'($random(seed)), 3, 1, (w < 4) ? 8'(w << 5) : 8'h10, 1'b0, 0);
      settle(0);
      `CHK(wrap_bits, (w < 4) ? 3'(w << 1) : 3'h1)
      `CHK(wrap_en, w < 4)
      `CHK(wrap_mask, (w < 4) ? 6'((8 << w) - 1) : 6'h07)
    end
    // Short, page-end wrap, overlong, quad, and 32H without quad enable
    for (int k = 0; k < 5; k++)
    begin
      a = 24'($random(seed)) & 24'h07ffff;
      bv = 8'($random(seed));
      if (k == 1)
        a[7:0] = 8'hff;
      quad_en = (k == 3);
      we_latch = 1'b1;
      launch((k > 2) ? 8'h32 : 8'h02, a, 3, nd[k], bv, k == 3, 0);
      settle(1);
      pchk(a, nd[k], bv);
    end
    // Every erase size lands on its aligned base
    for (int k = 0; k < 3; k++)
    begin
      a = 24'($random(seed)) & 24'h07ffff;
      we_latch = 1'b1;
      launch(eop[k], a, 3, 0, 8'h00, 1'b0, 0);
      settle(1);
      `CHK(ers_cnt, 1)
      `CHK(ers_k, ekind[k])
      `CHK(ers_a, a & ~(esz[k] - 24'h1))
    end
    // Refused frames: latch clear, stray bits, protected targets
    we_latch = 1'b0;
    launch(8'h02, a, 3, 2, bv, 1'b0, 0);
    settle(0);
    we_latch = 1'b1;
    launch(8'h20, a, 3, 0, bv, 1'b0, 3);
    settle(0);
    launch(8'h02, a, 3, 1, bv, 1'b0, 5);
    settle(0);
    // Bottom 16KB guarded: the sector inside is refused, the next one runs
    bp = 5'h0a;
    launch(8'h20, 24'h003000, 3, 0, bv, 1'b0, 0);
    settle(0);
    launch(8'h20, 24'h004abc, 3, 0, bv, 1'b0, 0);
    settle(1);
    `CHK(ers_a, 24'h004000)
    we_latch = 1'b1;
    bp = 5'h10;
    launch(8'h02, a, 3, 1, bv, 1'b0, 0);
    settle(0);
    launch(8'hd8, a, 3, 0, bv, 1'b0, 0);
    settle(0);
    `CHK(pgm_cnt + ers_cnt, 0)
    bp = 5'h00;
    // A second opcode during a long program is turned away
    launch(8'h02, a, 3, 258, bv, 1'b0, 0);
    host_u.send(8'h02, a, 0, 0, bv, 1'b0, 0);
    // A status read during the same cycle must not be turned away
    host_u.send(8'h05, a, 0, 1, bv, 1'b0, 0);
    settle(1);
    `CHK(rej_cnt, 1)
    `CHK(pgm_cnt, 256)
    end_sim();
  end

  // The plan needs about 4.6 ms; past 8 ms means a hang
  initial
  begin
    #8_000_000;
    num_errors++;
    end_sim();
  end
endmodule
`default_nettype wire
